// >>> sbsc_tester.sv
// sbsc_tester: tester end that drives the scan balls and reads bits back
// assumes: one device per instance; its gate ball is private to that device
`timescale 1ns/1ps
`default_nettype none

module sbsc_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// fill side
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady_q,
	// drain side
	output logic outValid_q,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	logic [AW:0] count_d;
	logic push;
	logic pop;

	assign push = inValid && inReady_q;
	assign pop = outValid_q && outReady;
	assign outData = mem_q[rdPtr_q];

	// occupancy; flags are registered from the next count
	always_comb begin
		count_d = count_q;
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= '0;
			inReady_q <= 1'b1;
			outValid_q <= 1'b0;
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			count_q <= count_d;
			inReady_q <= (count_d != (AW+1)'(DEPTH));
			outValid_q <= (count_d != '0);
			if (push) begin
				wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
			end
		end
	end

	// storage has no reset
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wrPtr_q] <= inData;
		end
	end
endmodule : sbsc_fifo

////////////////////////////////////////////////////////////////////////////////

module sbsc_tester
	import sbsc_pkg::*;
#(
	parameter int HALF = STROBE_HALF_CYC,
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// scan balls
	sbsc_if.tst link,
	// scan mode request, a level
	input wire logic scanEnableReq,
	// strobe requests
	input wire logic reqValid,
	input wire logic reqCapture,
	input wire logic reqGate,
	output logic reqReady_q,
	// read-back bits
	output logic bitValid_q,
	output logic bitData,
	input wire logic bitReady
);
	typedef enum {SBSC_IDLE, SBSC_SETUP, SBSC_HIGH, SBSC_LOW, SBSC_PUSH} sbsc_state_e;

	localparam int CW = $clog2(HALF + 1);

	sbsc_state_e state_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] settle_q;
	logic enable_q, select_q, strobe_q, gate_q;
	logic soutMeta_q, soutSync_q;
	logic fifoInReady;

	// enable is a plain level; reset leaves the device out of scan
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			enable_q <= ENABLE_RESET;
			settle_q <= '0;
		end else begin
			if (state_q == SBSC_IDLE) begin
				enable_q <= scanEnableReq; // RQ2
			end
			if (!enable_q) begin
				settle_q <= '0;
			end else if (settle_q != CW'(HALF)) begin
				settle_q <= settle_q + 1'b1;
			end
		end
	end

	// serial ball from the device: two flops before use
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			soutMeta_q <= 1'b0;
			soutSync_q <= 1'b0;
		end else begin
			soutMeta_q <= link.scanSerialLevel;
			soutSync_q <= soutMeta_q;
		end
	end

	// one strobe period per request: setup, high, low, then read back if gated
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= SBSC_IDLE;
			cnt_q <= '0;
			select_q <= 1'b0;
			strobe_q <= 1'b0;
			gate_q <= GATE_RESET;
			reqReady_q <= 1'b0;
		end else begin
			case (state_q)
				SBSC_IDLE: begin
					reqReady_q <= enable_q && (settle_q == CW'(HALF));
					if (reqValid && reqReady_q) begin
						select_q <= !reqCapture; // RQ3
						gate_q <= reqGate; // RQ13
						reqReady_q <= 1'b0;
						cnt_q <= '0;
						state_q <= SBSC_SETUP;
					end
				end
				SBSC_SETUP: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == CW'(HALF - 1)) begin
						strobe_q <= 1'b1; // RQ4
						cnt_q <= '0;
						state_q <= SBSC_HIGH;
					end
				end
				SBSC_HIGH: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == CW'(HALF - 1)) begin
						strobe_q <= 1'b0; // RQ5
						cnt_q <= '0;
						state_q <= SBSC_LOW;
					end
				end
				SBSC_LOW: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == CW'(HALF - 1)) begin
						cnt_q <= '0;
						state_q <= gate_q ? SBSC_PUSH : SBSC_IDLE;
					end
				end
				SBSC_PUSH: begin
					// stalls here while the buffer is full
					if (fifoInReady) begin
						state_q <= SBSC_IDLE;
					end
				end
				default: begin
					state_q <= SBSC_IDLE;
				end
			endcase
		end
	end

	assign link.scanModeSelect = enable_q;
	assign link.captureShiftSelect = select_q;
	assign link.scanStrobe = strobe_q;
	assign link.scanOutputGate = gate_q;

	sbsc_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(DEPTH)
	) u_fifo (
		.clock(clock),
		.reset_n(reset_n),
		.inValid(state_q == SBSC_PUSH),
		.inData(soutSync_q),
		.inReady_q(fifoInReady),
		.outValid_q(bitValid_q),
		.outData(bitData),
		.outReady(bitReady)
	);

endmodule : sbsc_tester

`default_nettype wire

// >>> sbsc_pkg.sv
// sbsc_pkg: shared constants for the pad boundary scan path
// assumes: both ends and the bench import it; no process lives here
package sbsc_pkg;

	// system clock of both ends
	localparam int CLK_PERIOD_NS = 25;

	// chain geometry; position p sits at chain index p-1
	localparam int CHAIN_LEN = 67;
	localparam int RSVD_POS_LO = 57;
	localparam int RSVD_POS_HI = 58;

	// scan strobe timing made by the tester
	localparam int STROBE_MIN_PERIOD_NS = 40;
	localparam int STROBE_HALF_NS = 100;
	localparam int STROBE_HALF_CYC = (STROBE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// synchroniser length for every ball input
	localparam int SYNC_STAGES = 2;

	// tester read-back buffer
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_WIDTH = 1;

	// termination modes reported by the device
	localparam logic [1:0] TERM_CALIBRATED = 2'h0;
	localparam logic [1:0] TERM_NOMINAL = 2'h1;
	localparam logic [1:0] TERM_OFF = 2'h2;

	// ball index inside the device synchroniser vector
	localparam int BALL_ENABLE = 0;
	localparam int BALL_SELECT = 1;
	localparam int BALL_STROBE = 2;
	localparam int BALL_GATE = 3;
	localparam int BALL_COUNT = 4;

	// reset values
	localparam logic GATE_RESET = 1'b0;
	localparam logic ENABLE_RESET = 1'b0;

endpackage : sbsc_pkg

// >>> sbsc_if.sv
// sbsc_if: scan balls between the tester and the device
// assumes: a bench instantiates it and ties both ends to it
`timescale 1ns/1ps
`default_nettype none

interface sbsc_if;
	// tester driven balls
	logic scanModeSelect;
	logic captureShiftSelect;
	logic scanStrobe;
	logic scanOutputGate;
	// device driven ball, shared with the lane-0 write strobe
	logic scanSerialOut;
	logic scanSerialOutEn;
	// resolved ball level; undriven ball reads low through a pull-down
	logic scanSerialLevel;

	assign scanSerialLevel = scanSerialOutEn ? scanSerialOut : 1'b0;

	modport dev (
		input scanModeSelect,
		input captureShiftSelect,
		input scanStrobe,
		input scanOutputGate,
		output scanSerialOut,
		output scanSerialOutEn
	);

	modport tst (
		output scanModeSelect,
		output captureShiftSelect,
		output scanStrobe,
		output scanOutputGate,
		input scanSerialLevel
	);
endinterface : sbsc_if

`default_nettype wire

// >>> sbsc_device.sv
// sbsc_device: device end of the reduced pad boundary scan path
// assumes: balls arrive asynchronous to clock; pads are static while captured
//
// Contract
// RQ1: high enable enters scan, low leaves it
// RQ2: tester holds enable low when unused
// RQ3: strobe captures when select low, shifts when high
// RQ4: scan inputs taken on strobe rising edge
// RQ5: strobe may be single pulse or burst
// RQ6: serial out driven only while gate sampled high
// RQ7: 67 positions, zeros shift in behind
// RQ8: positions 57 and 58 read zero
// RQ9: no ball swap while in scan
// RQ10: no commands executed while enable high
// RQ11: tester initialises device before enabling scan
// RQ12: scan sets nominal address termination, data off
// RQ13: two devices share enable, separate gates
// RQ14: ball swap is a static level
// RQ15: tester power cycles device after scan
// RQ16: serial out shares lane-0 write strobe ball
// RQ17: position 1 leaves first, then 2 to 67
// RQ18: scan controls reuse reset, select, swap balls
`timescale 1ns/1ps
`default_nettype none

module sbsc_device
	import sbsc_pkg::*;
#(
	parameter int CHAIN = CHAIN_LEN
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// scan balls
	sbsc_if.dev link,
	// pad levels seen by the chain cells, index p-1 is position p
	input wire logic [CHAIN-1:0] padLevel,
	// normal command path
	input wire logic cmdValid,
	output logic cmdExecute_q,
	// lane-0 write strobe from the normal data path
	input wire logic writeStrobeLane0,
	input wire logic writeStrobeLane0En,
	// normal roles of the shared balls
	output logic chipReinitInput_q,
	output logic chipSelectN_q,
	output logic ballSwapActive_q,
	// mode and termination status
	output logic scanActive_q,
	output logic [1:0] addrTermMode_q,
	output logic [1:0] dataTermMode_q
);

	////////////////////////////////////////////////////////////////////////////
	// ball synchronisers

	logic [BALL_COUNT-1:0] ballMeta_q;
	logic [BALL_COUNT-1:0] ballSync_q;
	logic [BALL_COUNT-1:0] ballRaw;

	assign ballRaw[BALL_ENABLE] = link.scanModeSelect;
	assign ballRaw[BALL_SELECT] = link.captureShiftSelect;
	assign ballRaw[BALL_STROBE] = link.scanStrobe;
	assign ballRaw[BALL_GATE] = link.scanOutputGate;

	// first stage read only by the second
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ballMeta_q <= '0;
			ballSync_q <= '0;
		end else begin
			ballMeta_q <= ballRaw;
			ballSync_q <= ballMeta_q;
		end
	end

	logic enableLevel;
	logic selectLevel;
	logic strobeLevel;
	logic gateLevel;

	assign enableLevel = ballSync_q[BALL_ENABLE];
	assign selectLevel = ballSync_q[BALL_SELECT];
	assign strobeLevel = ballSync_q[BALL_STROBE];
	assign gateLevel = ballSync_q[BALL_GATE];

	////////////////////////////////////////////////////////////////////////////
	// scan mode and strobe edge

	logic strobePrev_q;
	logic strobeRise;

	// scan mode follows the enable level, no latching
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			scanActive_q <= ENABLE_RESET;
		end else begin
			scanActive_q <= enableLevel; // RQ1
		end
	end

	// strobe is not a clock: edges found by sampling, any pulse count works
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			strobePrev_q <= 1'b0;
		end else begin
			strobePrev_q <= strobeLevel; // RQ5
		end
	end

	// an edge only counts once the mode is already settled
	assign strobeRise = strobeLevel && !strobePrev_q && scanActive_q && enableLevel; // RQ4

	////////////////////////////////////////////////////////////////////////////
	// capture and shift chain

	logic [CHAIN-1:0] chain_q;
	logic [CHAIN-1:0] chain_d;
	logic [CHAIN-1:0] captureMask;
	logic [CHAIN-1:0] padMeta_q;
	logic [CHAIN-1:0] padSync_q;

	// pads are balls too: two flops, so a pad must stand a few cycles before capture
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			padMeta_q <= '0;
			padSync_q <= '0;
		end else begin
			padMeta_q <= padLevel;
			padSync_q <= padMeta_q;
		end
	end

	// reserved balls have no cell worth reading
	always_comb begin
		captureMask = '1;
		captureMask[RSVD_POS_LO-1] = 1'b0; // RQ8
		captureMask[RSVD_POS_HI-1] = 1'b0; // RQ8
	end

	// capture loads every cell; shift moves toward the output, ground behind
	always_comb begin
		chain_d = chain_q;
		if (strobeRise) begin
			if (!selectLevel) begin
				chain_d = padSync_q & captureMask; // RQ3
			end else begin
				chain_d = {1'b0, chain_q[CHAIN-1:1]}; // RQ3 RQ7 RQ17
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			chain_q <= '0;
		end else begin
			chain_q <= chain_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output gate, registered on the strobe edge

	logic gate_q;
	logic gate_d;

	// next gate; dropping out of scan closes it so the ball returns cleanly
	always_comb begin
		gate_d = gate_q;
		if (!enableLevel) begin
			gate_d = GATE_RESET;
		end else if (strobeRise) begin
			gate_d = gateLevel; // RQ4 RQ6
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gate_q <= GATE_RESET;
		end else begin
			gate_q <= gate_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// shared serial ball

	logic serialOut_q;
	logic serialOutEn_q;

	// in scan the ball carries chain position 1, otherwise the write strobe
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			serialOut_q <= 1'b0;
			serialOutEn_q <= 1'b0;
		end else if (scanActive_q) begin
			serialOut_q <= chain_d[0]; // RQ16 RQ17
			serialOutEn_q <= gate_d; // RQ6 same edge as the bit, a closed gate never shows it
		end else begin
			serialOut_q <= writeStrobeLane0; // RQ16
			serialOutEn_q <= writeStrobeLane0En;
		end
	end

	assign link.scanSerialOut = serialOut_q;
	assign link.scanSerialOutEn = serialOutEn_q;

	////////////////////////////////////////////////////////////////////////////
	// normal roles of the borrowed balls

	logic swapLatched_q;
	logic swapTaken_q;

	// swap level is a strap: caught once after reset release, never tracked
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			swapLatched_q <= 1'b0;
			swapTaken_q <= 1'b0;
		end else if (!swapTaken_q && !enableLevel) begin
			swapLatched_q <= gateLevel; // RQ14
			swapTaken_q <= 1'b1;
		end
	end

	// in scan the borrowed balls give nothing to the core
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			chipReinitInput_q <= 1'b0;
			chipSelectN_q <= 1'b1;
			ballSwapActive_q <= 1'b0;
		end else if (enableLevel) begin
			chipReinitInput_q <= 1'b0; // RQ18
			chipSelectN_q <= 1'b1; // RQ18
			ballSwapActive_q <= 1'b0; // RQ9
		end else begin
			chipReinitInput_q <= selectLevel;
			chipSelectN_q <= strobeLevel;
			ballSwapActive_q <= swapLatched_q && swapTaken_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command gate and termination

	// blocking on the raw synced level closes the gate a cycle sooner
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cmdExecute_q <= 1'b0;
		end else begin
			cmdExecute_q <= cmdValid && !enableLevel && !scanActive_q; // RQ10
		end
	end

	// fixed termination in scan, so no calibration run is needed
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			addrTermMode_q <= TERM_CALIBRATED;
			dataTermMode_q <= TERM_CALIBRATED;
		end else if (enableLevel) begin
			addrTermMode_q <= TERM_NOMINAL; // RQ12
			dataTermMode_q <= TERM_OFF; // RQ12
		end else begin
			addrTermMode_q <= TERM_CALIBRATED;
			dataTermMode_q <= TERM_CALIBRATED;
		end
	end

endmodule : sbsc_device

`default_nettype wire

// >>> sbsc_chk.sv
// sbsc_chk: timing relations on the scan balls between tester and device
// assumes: one clock domain; instantiated beside the interface in the bench
`timescale 1ns/1ps
`default_nettype none

module sbsc_chk (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// scan balls
	input wire logic scanModeSelect,
	input wire logic captureShiftSelect,
	input wire logic scanStrobe,
	input wire logic scanOutputGate,
	input wire logic scanSerialOut,
	input wire logic scanSerialOutEn
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////
	// gate taken with the strobe edge decides the ball drive until the next edge
	property p_gate_on;
		$rose(scanStrobe) && scanModeSelect && scanOutputGate |-> ##5 scanSerialOutEn [*3];
	endproperty
	a_gate_on: assert property (p_gate_on) else $error("ball idle after gated strobe");
	property p_gate_off;
		$rose(scanStrobe) && scanModeSelect && !scanOutputGate |-> ##5 !scanSerialOutEn [*3];
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("ball driven without gate");
	// no strobe, no movement; 8 cycles hides the mode entry latency
	property p_quiet;
		(scanModeSelect && !scanStrobe) [*8] |-> $stable(scanSerialOut) && $stable(scanSerialOutEn);
	endproperty
	a_quiet: assert property (p_quiet) else $error("ball moved without strobe");
	// select and gate settle before the rise and hold past the fall
	property p_setup;
		$rose(scanStrobe) |-> $past(captureShiftSelect, 3) == captureShiftSelect
			&& $past(scanOutputGate, 3) == scanOutputGate;
	endproperty
	a_setup: assert property (p_setup) else $error("select moved just before strobe");
	property p_hold;
		$fell(scanStrobe) |-> $stable(captureShiftSelect) && $stable(scanOutputGate);
	endproperty
	a_hold: assert property (p_hold) else $error("select moved at strobe fall");
	// mode must be settled well ahead of any strobe
	property p_mode_first;
		$rose(scanStrobe) |-> scanModeSelect && $past(scanModeSelect, 8);
	endproperty
	a_mode_first: assert property (p_mode_first) else $error("strobe without settled mode");
	property p_width;
		$rose(scanStrobe) |-> scanStrobe [*4] ##1 !scanStrobe;
	endproperty
	a_width: assert property (p_width) else $error("strobe pulse width wrong");
	property p_idle;
		!scanModeSelect |-> !scanStrobe;
	endproperty
	a_idle: assert property (p_idle) else $error("strobe outside scan mode");
endmodule : sbsc_chk

`default_nettype wire

// >>> sbsc_tb_top.sv
// sbsc_tb_top: tester and device joined by the scan interface, self-checking
// assumes: design files and sbsc_chk compiled first
`timescale 1ns/1ps
`default_nettype none

module sbsc_tb_top
	import sbsc_pkg::*;
;
	logic clock = 1'h0, reset_n = 1'h0;
	logic [CHAIN_LEN-1:0] padLevel = '0, pad = '0;
	logic cmdValid = 1'h0, writeStrobeLane0 = 1'h0, writeStrobeLane0En = 1'h0;
	logic scanEnableReq = 1'h0, reqValid = 1'h0, reqCapture = 1'h0, reqGate = 1'h0, bitReady = 1'h0;
	logic cmdExecute_q, chipReinitInput_q, chipSelectN_q, ballSwapActive_q, scanActive_q;
	logic [1:0] addrTermMode_q, dataTermMode_q;
	logic reqReady_q, bitValid_q, bitData, stall = 1'h0;
	logic [7:0] seedA = 8'h2c, seedB = 8'h2c;
	logic expQ[$];
	int errCount = 0, totalChecks = 0, cycles = 0, mode = 0, pos = 0;

	sbsc_if i_sbsc_if ();
	sbsc_device i_sbsc_device (.clock, .reset_n, .link(i_sbsc_if), .padLevel, .cmdValid, .cmdExecute_q,
		.writeStrobeLane0, .writeStrobeLane0En, .chipReinitInput_q, .chipSelectN_q, .ballSwapActive_q,
		.scanActive_q, .addrTermMode_q, .dataTermMode_q);
	sbsc_tester i_sbsc_tester (.clock, .reset_n, .link(i_sbsc_if), .scanEnableReq, .reqValid, .reqCapture,
		.reqGate, .reqReady_q, .bitValid_q, .bitData, .bitReady);
	sbsc_chk i_sbsc_chk (.clock, .reset_n, .scanModeSelect(i_sbsc_if.scanModeSelect),
		.captureShiftSelect(i_sbsc_if.captureShiftSelect), .scanStrobe(i_sbsc_if.scanStrobe),
		.scanOutputGate(i_sbsc_if.scanOutputGate), .scanSerialOut(i_sbsc_if.scanSerialOut),
		.scanSerialOutEn(i_sbsc_if.scanSerialOutEn));

	////////////////////////////////////////
	// clock
	always #(CLK_PERIOD_NS / 2.0) clock = ~clock;

	function automatic logic [7:0] nx(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : nx

	// bit expected for a chain position; zeros behind the end and on reserved balls
	function automatic logic expBit(input int p);
		return (p > CHAIN_LEN || p == RSVD_POS_LO || p == RSVD_POS_HI) ? 1'h0 : pad[p-1];
	endfunction : expBit

	task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string what);
		totalChecks++;
		if (got !== exp) begin
			errCount++;
			$display("[FAIL] %0t %s got %b want %b", $time, what, got, exp);
		end
	endtask : chk

	task automatic close_out;
		if (errCount == 0 && totalChecks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	// one strobe request; valid stays up so back-to-back calls never re-assign it in one step
	task automatic req(input logic c, input logic g);
		logic rdy;
		int n;
		n = 0;
		reqValid = 1'h1;
		reqCapture = c;
		reqGate = g;
		rdy = reqReady_q;
		// ready read settled, off the edge; the edge after a high read takes the request
		while (rdy !== 1'h1 && n < 200) begin
			@(posedge clock);
			#2;
			rdy = reqReady_q;
			n++;
		end
		@(posedge clock);
		#2;
		chk(rdy !== 1'h1, 1'h0, "request refused");
		pos = c ? 1 : pos + 1;
		if (g) expQ.push_back(expBit(pos));
	endtask : req

	// wait for all expected bits and an idle tester
	task automatic drain;
		int n;
		n = 0;
		// no stale request may be taken again once the tester goes idle
		reqValid = 1'h0;
		do begin
			@(posedge clock);
			#2;
			n++;
		end while (n < 400 && (expQ.size() > 0 || reqReady_q !== 1'h1));
		chk(expQ.size() > 0, 1'h0, "bits missing");
	endtask : drain

	// fresh pads, capture with gate, then shifts past the chain end
	task automatic round(input logic rsv);
		int i;
		for (i = 0; i < CHAIN_LEN; i++) begin
			seedB = nx(seedB);
			pad[i] = seedB[0];
		end
		if (rsv) pad[RSVD_POS_HI-1 -: 2] = 2'h3;
		padLevel = pad;
		req(1'h1, 1'h1);
		mode = 2;
		for (i = 2; i <= CHAIN_LEN + 4; i++) begin
			seedB = nx(seedB);
			req(1'h0, seedB[0] || (i > 54 && i < 60) || i > 65);
		end
	endtask : round

	////////////////////////////////////////
	// hang guard; a full run takes about 2500 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 8000) begin
			errCount++;
			$display("[FAIL] %0t run hung", $time);
			close_out();
		end
	end

	// background traffic and per-cycle mode checks
	always @(posedge clock) begin
		#1;
		if (mode == 1) begin
			chk(cmdExecute_q, cmdValid, "command path");
			chk(i_sbsc_if.scanSerialLevel, writeStrobeLane0En & writeStrobeLane0, "strobe ball");
			chk({chipReinitInput_q, chipSelectN_q}, 2'h0, "normal balls");
			chk(ballSwapActive_q, 1'h0, "swap strap");
		end
		if (mode == 2) begin
			chk(cmdExecute_q, 1'h0, "command ran in scan");
			chk({chipReinitInput_q, chipSelectN_q}, 2'h1, "shared balls");
			chk({ballSwapActive_q, scanActive_q}, 2'h1, "swap or mode");
			chk(addrTermMode_q, TERM_NOMINAL, "addr term");
			chk(dataTermMode_q, TERM_OFF, "data term");
		end
		#1;
		seedA = nx(seedA);
		cmdValid = seedA[0];
		writeStrobeLane0 = seedA[1];
		writeStrobeLane0En = seedA[2];
		bitReady = !stall && seedA[3];
	end

	// read-back bits compared against the chain order; sampled settled, before the popping edge
	always @(negedge clock) begin
		if (bitValid_q === 1'h1 && bitReady === 1'h1) begin
			if (expQ.size() == 0) begin
				chk(2'h3, 2'h0, "extra bit");
			end else begin
				chk(bitData, expQ.pop_front(), "scan bit");
			end
		end
	end

	// main sequence
	initial begin
		repeat (6) @(posedge clock);
		#2;
		reset_n = 1'h1;
		repeat (3) @(posedge clock);
		#2;
		mode = 1;
		repeat (100) @(posedge clock);
		#2;
		mode = 0;
		scanEnableReq = 1'h1;
		round(1'h1);
		drain();
		// buffer of 8 fills, the ninth gated request must stall the tester
		stall = 1'h1;
		for (int i = 0; i < 9; i++) req(i == 0, 1'h1);
		repeat (40) @(posedge clock);
		#2;
		chk({reqReady_q, bitValid_q}, 2'h1, "buffer full");
		stall = 1'h0;
		drain();
		round(1'h0);
		drain();
		reqValid = 1'h0;
		mode = 0;
		scanEnableReq = 1'h0;
		repeat (30) @(posedge clock);
		#2;
		chk(scanActive_q, 1'h0, "scan not left");
		// device is reinitialised before normal use resumes
		reset_n = 1'h0;
		repeat (2) @(posedge clock);
		#2;
		reset_n = 1'h1;
		repeat (3) @(posedge clock);
		#2;
		mode = 1;
		repeat (100) @(posedge clock);
		#2;
		close_out();
	end
endmodule : sbsc_tb_top

`default_nettype wire
